// file: design/reset_seq_pkg.sv
// Package with timing constants, states and carrier structs for the reset sequencer
package reset_seq_pkg;
  localparam int unsigned SYS_CLK_MHZ = 250;
  localparam int unsigned IN_ASSERT_CYCLES = 32;
  localparam int unsigned OUT_ASSERT_CYCLES = 512;
  localparam int unsigned NEG_GAP_CYCLES = 16;
  localparam int unsigned STRAP_SETUP_CYCLES = 4;
  localparam int unsigned STRAP_OFF_NS = 4;
  localparam int unsigned STRAP_ON_CYCLES = 1;
  localparam int unsigned PLL_LOCK_US = 100;
  localparam int unsigned PLL_LOCK_SYS = PLL_LOCK_US * SYS_CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned SRC_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
  localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;

  typedef enum logic [2:0] {
    ST_POR,
    ST_PLL_WAIT,
    ST_HOLD,
    ST_SOFT_GAP,
    ST_RUN
  } seq_state_type;

  typedef struct packed {
    logic power_on_reset_n;
    logic hard_reset_n;
    logic soft_reset_n;
  } reset_in_type;

  typedef struct packed {
    logic [SRC_W-1:0] reset_source;
    logic input_clock_divide_strap;
  } strap_type;
endpackage

// file: design/reset_init_sequencer.sv
// Reset initialization sequencer: input qualification, output sequencing, strap capture
// Overview of operation
// (RULE1) Hard/soft reset input held 32 sync periods
// (RULE2) Host mode power-on reset held 32 input clocks
// (RULE3) Agent mode power-on reset held 32 sync clocks
// (RULE4) Outputs held 512; soft negates 16 after hard
// (RULE5) Straps valid 4 clocks before power-on negation
// (RULE6) Strap drivers off within 4 ns of hard
// (RULE7) Strap drivers resume 1 sync period after hard
// (RULE8) Wait PLL lock time before release
// (RULE9) Host sync period follows clock-divide strap
// (RULE10) Reference clock from input pin or bus clock
// (RULE11) Cycle counter; restart on any reset reassertion; code restarts only after 32 ticks, ignoring hard/soft while driving hard
`timescale 1ns/1ns
`default_nettype none
module reset_init_sequencer #(
  parameter int unsigned PLL_LOCK_CYCLES = reset_seq_pkg::PLL_LOCK_SYS
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_mode,
  input wire logic primary_input_clock,
  input wire logic bus_clock,
  input wire logic pll_locked,
  input wire reset_seq_pkg::reset_in_type reset_in,
  input wire reset_seq_pkg::strap_type strap_in,
  input wire reset_seq_pkg::strap_type strap_core_out,
  output logic hard_reset_out_n,
  output logic hard_reset_oe_n,
  output logic soft_reset_out_n,
  output logic soft_reset_oe_n,
  output reset_seq_pkg::strap_type strap_out,
  output logic strap_oe_n,
  output reset_seq_pkg::strap_type strap_latched_ff,
  output logic core_ready
);
  reset_seq_pkg::seq_state_type state_ff;
  reset_seq_pkg::seq_state_type nxt_state;
  logic ref_clk_ff;
  logic ref_prev_ff;
  logic [reset_seq_pkg::DIV_W-1:0] div_cnt_ff;
  logic [reset_seq_pkg::CNT_W-1:0] por_cnt_ff;
  logic [reset_seq_pkg::CNT_W-1:0] hs_cnt_ff;
  logic [reset_seq_pkg::CNT_W-1:0] seq_cnt_ff;
  logic [reset_seq_pkg::CNT_W-1:0] nxt_seq_cnt;
  logic strap_wait_ff;
  logic [31:0] pll_cnt_ff;
  logic por_prev_ff;
  logic hard_ff;
  logic soft_ff;
  logic strap_drive_ff;
  logic [reset_seq_pkg::DIV_W-1:0] div_ratio;
  logic ref_pick;
  logic ref_tick;
  logic sync_tick;
  logic por_asserted;
  logic hs_asserted;
  logic por_qual;
  logic hs_qual;
  logic restart;
  logic por_release;
  logic pll_done;

  // Reference clock pins are sampled as synchronous levels, so rising edges are seen as ticks
  assign ref_pick = host_mode ? primary_input_clock : bus_clock; // see (RULE10)
  assign ref_tick = ref_clk_ff & ~ref_prev_ff;
  // Divide strap 1 halves the input clock to make the sync period in host mode
  assign div_ratio = strap_latched_ff.input_clock_divide_strap ? reset_seq_pkg::DIV_ONE
                                                               : reset_seq_pkg::DIV_ZERO; // see (RULE9)
  assign sync_tick = ref_tick & (!host_mode || div_cnt_ff == div_ratio); // see (RULE9)
  assign por_asserted = !reset_in.power_on_reset_n;
  assign hs_asserted = !reset_in.hard_reset_n || !reset_in.soft_reset_n;
  // Host counts raw input clocks, agent counts sync clocks
  assign por_qual = por_cnt_ff >= reset_seq_pkg::CNT_W'(reset_seq_pkg::IN_ASSERT_CYCLES); // see (RULE2) (RULE3)
  assign hs_qual = hs_cnt_ff >= reset_seq_pkg::CNT_W'(reset_seq_pkg::IN_ASSERT_CYCLES); // see (RULE1)
  assign restart = (por_asserted && por_qual) || (hs_asserted && hs_qual); // see (RULE11)
  assign por_release = por_prev_ff && !por_asserted;
  assign pll_done = pll_locked && pll_cnt_ff >= PLL_LOCK_CYCLES; // see (RULE8)

  always_comb
  begin
    nxt_state = state_ff;
    nxt_seq_cnt = seq_cnt_ff;
    if (sync_tick && seq_cnt_ff != reset_seq_pkg::CNT_ZERO)
    begin
      nxt_seq_cnt = seq_cnt_ff - reset_seq_pkg::CNT_ONE;
    end
    unique case (state_ff)
      reset_seq_pkg::ST_POR:
      begin
        if (!por_asserted)
        begin
          nxt_state = reset_seq_pkg::ST_PLL_WAIT;
        end
      end
      reset_seq_pkg::ST_PLL_WAIT:
      begin
        nxt_seq_cnt = reset_seq_pkg::CNT_W'(reset_seq_pkg::OUT_ASSERT_CYCLES);
        if (pll_done)
        begin
          nxt_state = reset_seq_pkg::ST_HOLD; // see (RULE8)
        end
      end
      reset_seq_pkg::ST_HOLD:
      begin
        if (seq_cnt_ff == reset_seq_pkg::CNT_ZERO)
        begin
          nxt_state = reset_seq_pkg::ST_SOFT_GAP; // see (RULE4)
          nxt_seq_cnt = reset_seq_pkg::CNT_W'(reset_seq_pkg::NEG_GAP_CYCLES);
        end
      end
      reset_seq_pkg::ST_SOFT_GAP:
      begin
        if (seq_cnt_ff == reset_seq_pkg::CNT_ZERO)
        begin
          nxt_state = reset_seq_pkg::ST_RUN; // see (RULE4)
        end
      end
      reset_seq_pkg::ST_RUN:
      begin
        nxt_state = reset_seq_pkg::ST_RUN;
      end
    endcase
    if (restart)
    begin
      nxt_state = por_asserted ? reset_seq_pkg::ST_POR : reset_seq_pkg::ST_PLL_WAIT; // see (RULE11)
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= reset_seq_pkg::ST_POR;
      seq_cnt_ff <= reset_seq_pkg::CNT_ZERO;
      ref_clk_ff <= 1'b0;
      ref_prev_ff <= 1'b0;
      div_cnt_ff <= reset_seq_pkg::DIV_ZERO;
      por_prev_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      seq_cnt_ff <= nxt_seq_cnt;
      ref_clk_ff <= ref_pick;
      ref_prev_ff <= ref_clk_ff;
      por_prev_ff <= por_asserted;
      if (ref_tick)
      begin
        div_cnt_ff <= (div_cnt_ff == div_ratio) ? reset_seq_pkg::DIV_ZERO : div_cnt_ff + reset_seq_pkg::DIV_ONE;
      end
    end
  end

  // Assertion-length counters saturate so long holds never wrap into a false short one
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      por_cnt_ff <= reset_seq_pkg::CNT_ZERO;
      hs_cnt_ff <= reset_seq_pkg::CNT_ZERO;
      pll_cnt_ff <= 32'h0000_0000;
    end
    else
    begin
      if (!por_asserted)
        por_cnt_ff <= reset_seq_pkg::CNT_ZERO;
      else if ((host_mode ? ref_tick : sync_tick) && !por_qual)
        por_cnt_ff <= por_cnt_ff + reset_seq_pkg::CNT_ONE; // see (RULE2) (RULE3)
      if (!hs_asserted || hard_ff)
        hs_cnt_ff <= reset_seq_pkg::CNT_ZERO;
      else if (sync_tick && !hs_qual)
        hs_cnt_ff <= hs_cnt_ff + reset_seq_pkg::CNT_ONE; // see (RULE1)
      if (state_ff != reset_seq_pkg::ST_PLL_WAIT)
        pll_cnt_ff <= 32'h0000_0000;
      else if (pll_cnt_ff < PLL_LOCK_CYCLES)
        pll_cnt_ff <= pll_cnt_ff + 32'h0000_0001; // see (RULE8)
    end
  end

  // Straps follow the pins through power-on and freeze on its release cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      strap_latched_ff <= '0;
    end
    else
    begin
      if (por_asserted || por_release)
        strap_latched_ff <= strap_in; // see (RULE5)
    end
  end

  // Hard low until soft gap; strap drivers drop in the same cycle to beat 4 ns
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hard_ff <= 1'b1;
      soft_ff <= 1'b1;
      strap_wait_ff <= 1'b0;
      strap_drive_ff <= 1'b0;
    end
    else
    begin
      hard_ff <= nxt_state == reset_seq_pkg::ST_POR || nxt_state == reset_seq_pkg::ST_PLL_WAIT
                 || nxt_state == reset_seq_pkg::ST_HOLD; // see (RULE4)
      soft_ff <= nxt_state != reset_seq_pkg::ST_RUN; // see (RULE4)
      // The first tick after release may come early, so drive only from the second one
      if (hard_ff || nxt_state == reset_seq_pkg::ST_HOLD)
      begin
        strap_wait_ff <= 1'b0;
        strap_drive_ff <= 1'b0; // see (RULE6)
      end
      else if (sync_tick)
      begin
        strap_wait_ff <= 1'b1;
        strap_drive_ff <= strap_wait_ff; // see (RULE7)
      end
    end
  end

  assign hard_reset_out_n = 1'b0;
  assign hard_reset_oe_n = !hard_ff;
  assign soft_reset_out_n = 1'b0;
  assign soft_reset_oe_n = !soft_ff;
  assign strap_out = strap_core_out;
  // Combinational release so drivers drop the same cycle hard reset starts
  assign strap_oe_n = !(strap_drive_ff && !hard_ff); // see (RULE6)
  assign core_ready = !soft_ff;
endmodule
`default_nettype wire

// file: tb/reset_board_model.sv
// Board side: reset supervisor, strap drivers, reference clocks
`timescale 1ns/1ns
`default_nettype none
module reset_board_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_go,
  input wire logic hard_go,
  input wire reset_seq_pkg::strap_type board_straps,
  input wire reset_seq_pkg::strap_type strap_out,
  input wire logic strap_oe_n,
  input wire logic hard_oe_n,
  output logic in_clk,
  output logic bus_clk,
  output reset_seq_pkg::reset_in_type reset_in,
  output reset_seq_pkg::strap_type strap_in
);
  logic [9:0] cnt_ff;
  logic hard_ff;
  logic [2:0] div_ff;
  // 300 cycles covers 32 ticks of the slowest reference in any phase
  always_ff @(posedge sys_clk)
  begin
    div_ff <= rst_n ? div_ff + 3'h1 : 3'h0;
    if (!rst_n || por_go || hard_go)
    begin
      cnt_ff <= 10'h12C;
      hard_ff <= hard_go;
    end
    else if (cnt_ff != 10'h000)
      cnt_ff <= cnt_ff - 10'h001;
  end
  assign in_clk = div_ff[1];
  assign bus_clk = div_ff[2];
  // Open drain: the hard reset pin is low while either party pulls
  assign reset_in = '{power_on_reset_n: cnt_ff == 10'h000 || hard_ff,
                      hard_reset_n: (cnt_ff == 10'h000 || !hard_ff) && hard_oe_n,
                      soft_reset_n: 1'b1};
  assign strap_in = strap_oe_n ? board_straps : strap_out;
endmodule
`default_nettype wire

// file: tb/reset_init_sequencer_chk.sv
// Assertions on the reset sequencer outputs
`timescale 1ns/1ns
`default_nettype none
module reset_seq_chk #(
  parameter int unsigned PLL_LOCK_CYCLES = 20
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire reset_seq_pkg::reset_in_type reset_in,
  input wire reset_seq_pkg::strap_type strap_core_out,
  input wire logic hard_reset_oe_n,
  input wire logic soft_reset_oe_n,
  input wire reset_seq_pkg::strap_type strap_out,
  input wire logic strap_oe_n,
  input wire reset_seq_pkg::strap_type strap_latched_ff,
  input wire logic core_ready
);
  logic [15:0] low_ff;
  logic [15:0] gap_ff;
  // Shortest sync period in this bench is 4 cycles, so 512 ticks span at least 2048
  always_ff @(posedge sys_clk)
    low_ff <= (!rst_n || hard_reset_oe_n) ? 16'h0000 : low_ff + 16'h0001;
  always_ff @(posedge sys_clk)
    gap_ff <= (!rst_n || !hard_reset_oe_n || soft_reset_oe_n) ? 16'h0000 : gap_ff + 16'h0001;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_strap_off_hard: assert property (!hard_reset_oe_n |-> strap_oe_n)
    else $error("straps driven in hard reset");
  a_hold_min: assert property ($rose(hard_reset_oe_n) |-> $past(low_ff) >= 16'h0800)
    else $error("hard reset too short");
  a_pll_wait: assert property ($rose(hard_reset_oe_n) |-> $past(low_ff) > PLL_LOCK_CYCLES)
    else $error("no lock wait");
  a_soft_gap: assert property ($rose(soft_reset_oe_n) |-> gap_ff >= 16'h0040)
    else $error("soft released early");
  a_strap_resume: assert property ($rose(hard_reset_oe_n) |-> strap_oe_n [*4])
    else $error("straps resumed early");
  a_ready_order: assert property (core_ready |-> hard_reset_oe_n && soft_reset_oe_n)
    else $error("ready in reset");
  a_ready_drive: assert property (core_ready |-> !strap_oe_n && strap_out == strap_core_out)
    else $error("straps not driven");
  a_strap_hold: assert property (reset_in.power_on_reset_n && $past(reset_in.power_on_reset_n)
    |-> $stable(strap_latched_ff)) else $error("straps relatched");
  cover property ($rose(core_ready));
  cover property ($fell(hard_reset_oe_n));
  cover property ($rose(hard_reset_oe_n));
endmodule
bind reset_init_sequencer reset_seq_chk #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) chk_i (.sys_clk, .rst_n,
  .reset_in, .strap_core_out, .hard_reset_oe_n, .soft_reset_oe_n, .strap_out, .strap_oe_n,
  .strap_latched_ff, .core_ready);
`default_nettype wire

// file: tb/tb_reset_init_sequencer.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_reset_init_sequencer;
  logic sys_clk = 0, rst_n = 0, host_mode = 0, pll_locked = 1, por_go = 0, hard_go = 0;
  logic in_clk, bus_clk, hard_oe_n, soft_oe_n, strap_oe_n, core_ready, hard_lvl, soft_lvl;
  reset_seq_pkg::reset_in_type reset_in;
  reset_seq_pkg::strap_type straps = 4'h3, strap_in, strap_out, latched;
  int error_cnt = 0, total_checks = 0, c, g;
  reset_init_sequencer #(.PLL_LOCK_CYCLES(20)) dut (.sys_clk, .rst_n, .host_mode,
    .primary_input_clock(in_clk), .bus_clock(bus_clk), .pll_locked, .reset_in, .strap_in,
    .strap_core_out(~straps), .hard_reset_out_n(hard_lvl), .hard_reset_oe_n(hard_oe_n),
    .soft_reset_out_n(soft_lvl), .soft_reset_oe_n(soft_oe_n), .strap_out, .strap_oe_n,
    .strap_latched_ff(latched), .core_ready);
  reset_board_model model (.sys_clk, .rst_n, .por_go, .hard_go, .board_straps(straps), .strap_out,
    .strap_oe_n, .hard_oe_n, .in_clk, .bus_clk, .reset_in, .strap_in);
  initial forever #2 sys_clk = ~sys_clk;
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    error_cnt += (s !== e);
    if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
  endtask
  task close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One release after power-on; p is sys_clk cycles per sync tick
  task seq(input int p, input logic [3:0] exp);
    // Let the model take its strobe before looking at the power-on pin
    @(negedge sys_clk);
    for (c = 0; c < 900 && reset_in.power_on_reset_n !== 1'b1; c++) @(negedge sys_clk);
    for (c = 0; c < 20000 && hard_oe_n !== 1'b1; c++) @(negedge sys_clk);
    // Lock count of 20, then 512 ticks of which the first lands 1 to p cycles into the hold
    chk("hold", c >= 24 + 511 * p && c <= 24 + 512 * p, 1);
    for (g = 0; g < 2000 && soft_oe_n !== 1'b1; g++) @(negedge sys_clk);
    chk("gap", g >= 16 * p && g <= 18 * p, 1);
    chk("ready", core_ready, 1);
    chk("pin level", {hard_lvl, soft_lvl}, 16'h0000);
    chk("strap drive", strap_oe_n, 0);
    chk("latched", latched, exp);
  endtask
  task t_host(input logic [3:0] s, input int p);
    @(posedge sys_clk);
    host_mode <= 1;
    straps <= s;
    por_go <= 1;
    @(posedge sys_clk);
    por_go <= 0;
    seq(p, s);
  endtask
  // A long hard reset input restarts the flow but keeps the latched straps
  task t_hard();
    @(posedge sys_clk);
    hard_go <= 1;
    pll_locked <= 0;
    @(posedge sys_clk);
    hard_go <= 0;
    for (c = 0; c < 400 && hard_oe_n !== 1'b0; c++) @(negedge sys_clk);
    chk("restart", c >= 240 && c < 300, 1);
    chk("strap off", strap_oe_n, 1);
    // Longer than lock count plus 512 ticks, so a release here would ignore the lock
    repeat (4400) @(negedge sys_clk);
    chk("lock wait", hard_oe_n, 0);
    @(posedge sys_clk);
    pll_locked <= 1;
    for (c = 0; c < 9000 && soft_oe_n !== 1'b1; c++) @(negedge sys_clk);
    chk("back", core_ready, 1);
    chk("kept", latched, 4'h5);
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    seq(8, 4'h3);
    t_host(4'hA, 4);
    t_host(4'h5, 8);
    t_hard();
    close_out();
  end
endmodule
`default_nettype wire
